// ===== src/osp_one_shot_pwm.sv
// Triggered one-shot PWM timer with a classic Wishbone register slave
//
// Local design decisions: the Wishbone slave port and the register addresses.
`timescale 1ns/1ns
// How it works
// - One pulse: wait, active, then inactive
// - Stop bit halts counter as pulse ends
// - Counter steps once per selected source tick
// - Free period is m plus one ticks with clear set
// - Active width is n minus p ticks
// - Start to active is p plus one
// - No trigger or no stop: run starts
// - Trigger and stop set: run waits for edge
// - Run cleared stops, initial level, count kept
// - Period stop: initial level, optional clear
// - Request on compare match and overflow
// - Pulse pin output, channel A trigger
// - Cutoff input disables the pulse driver
// - Counter readable live and writable
// - Trigger edge rising, falling or both
// - Buffered compare, filtering, converter trigger
// - Edge code: off, rise, fall, both
// - Polarity picks initial and active levels
// - Clear bit resets counter on period
// - Three-bit code selects count source
module osp_one_shot_pwm import osp_pkg::*; (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic WB_CYC,
  input wire logic WB_STB,
  input wire logic WB_WE,
  input wire logic [7:0] WB_ADR,
  input wire logic [3:0] WB_SEL,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK,
  input wire logic CHAN_A_I,
  input wire logic EXT_CLK_I,
  input wire logic CUTOFF_N_I,
  input wire logic FAST_OSC_TICK,
  input wire logic FAST_OSC_DIV_TICK,
  output logic PULSE_OUT_O,
  output logic PULSE_OUT_OE_N,
  output logic IRQ_REQ,
  output logic ADC_TRIG
);
  osp_state_t s;
  osp_state_t next_s;
  osp_pin_t pins [NPINS];
  logic [NPINS-1:0] pin_in;
  logic [3:0] ev;
  logic tick;
  logic trig_hit;
  logic run;
  logic en;
  logic stop;
  logic clr;
  logic trig_mode;
  logic req;
  logic cnt_wr;
  osp_edge_t edge_sel;
  osp_src_t src;

  function automatic logic [31:0] lanes(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Trigger shares channel A; cutoff shares the external interrupt pin
  assign pin_in = {CUTOFF_N_I, EXT_CLK_I, CHAN_A_I};

  genvar g;
  generate
    for (g = 0; g < NPINS; g++) begin : g_pin
      osp_pin_sync u_sync (
        .clk(REF_CLK),
        .rst(RST),
        .pin(pin_in[g]),
        .filt_en(s.mode[MODE_FILT]),
        .q(pins[g])
      );
    end
  endgenerate

  assign run = s.mode[MODE_RUN];
  assign en = s.mode[MODE_EN];
  assign stop = s.ctrl2[CTRL2_STOP];
  assign clr = s.ctrl1[CTRL1_CLR];
  assign edge_sel = osp_edge_t'(s.ctrl2[CTRL2_EDGE +: 2]);
  assign src = osp_src_t'(s.ctrl1[CTRL1_SRC +: 3]);
  assign trig_mode = (edge_sel != EDGE_OFF) && stop;
  assign req = WB_CYC & WB_STB & ~s.ack;
  assign cnt_wr = req & WB_WE & (WB_ADR[7:2] == ADR_COUNT[7:2]);

  always_comb begin
    unique case (src)
      SRC_F1: tick = 1'b1;
      SRC_F2: tick = s.div[0];
      SRC_F4: tick = &s.div[1:0];
      SRC_F8: tick = &s.div[2:0];
      SRC_F32: tick = &s.div[4:0];
      SRC_EXT: tick = pins[PIN_ECLK].rise;
      SRC_OSC40: tick = FAST_OSC_TICK;
      SRC_OSCDIV: tick = FAST_OSC_DIV_TICK;
    endcase
  end

  always_comb begin
    unique case (edge_sel)
      EDGE_OFF: trig_hit = 1'b0;
      EDGE_RISE: trig_hit = pins[PIN_TRIG].rise;
      EDGE_FALL: trig_hit = pins[PIN_TRIG].fall;
      EDGE_BOTH: trig_hit = pins[PIN_TRIG].rise | pins[PIN_TRIG].fall;
    endcase
  end

  always_comb begin
    next_s = s;
    ev = 4'h0;
    next_s.ack = 1'b0;
    next_s.irq = 1'b0;
    next_s.adc = 1'b0;
    next_s.div = s.div + 5'h01;
    unique case (s.fsm)
      ST_IDLE: begin
        next_s.active = 1'b0;
        if (run && en) begin
          next_s.fsm = trig_mode ? ST_ARMED : ST_COUNT;
        end
      end
      ST_ARMED: begin
        next_s.active = 1'b0;
        if (!run || !en) begin
          next_s.fsm = ST_IDLE;
        end else if (trig_hit) begin
          next_s.fsm = ST_COUNT;
        end
      end
      ST_COUNT: begin
        if (!run || !en) begin
          // Counter is left alone so software can read where it stopped
          next_s.fsm = ST_IDLE;
          next_s.active = 1'b0;
        end else if (tick) begin
          next_s.cnt = s.cnt + 16'h0001;
          if (s.cnt == s.waitc) begin
            next_s.active = 1'b1;
            ev[EV_C] = 1'b1;
            next_s.adc = s.mode[MODE_ADC];
          end
          // End match overrides a wait match on the same count
          if (s.cnt == s.endc) begin
            next_s.active = 1'b0;
            ev[EV_B] = 1'b1;
          end
          if (s.cnt == s.period) begin
            ev[EV_A] = 1'b1;
            if (s.mode[MODE_BUF]) begin
              next_s.endc = s.bufd;
            end
            if (stop) begin
              next_s.active = 1'b0;
              next_s.cnt = clr ? COUNT_RST : s.cnt;
              next_s.fsm = trig_mode ? ST_ARMED : ST_IDLE;
              // Without a trigger the run bit drops, else it would restart at once
              if (!trig_mode) begin
                next_s.mode[MODE_RUN] = 1'b0;
              end
            end else if (clr) begin
              next_s.cnt = COUNT_RST;
            end
          end
          if (s.cnt == COUNT_MAX && next_s.cnt == COUNT_RST) begin
            ev[EV_OVF] = 1'b1;
          end
        end
      end
      default: next_s.fsm = ST_IDLE;
    endcase
    next_s.irq = |ev;
    // Flags set by events win over a clear in the same cycle
    next_s.stat = s.stat | ev;
    next_s.oe_n = ~(en & ~(s.mode[MODE_CUT] & ~pins[PIN_CUT].level));
    if (req) begin
      next_s.ack = 1'b1;
      next_s.rdat = 32'h0000_0000;
      unique case (WB_ADR[7:2])
        ADR_MODE[7:2]: next_s.rdat = {26'h000_0000, s.mode};
        ADR_CTRL1[7:2]: next_s.rdat = {24'h00_0000, s.ctrl1};
        ADR_CTRL2[7:2]: next_s.rdat = {24'h00_0000, s.ctrl2 | CTRL2_ONES};
        ADR_COUNT[7:2]: next_s.rdat = {16'h0000, s.cnt};
        ADR_PERIOD[7:2]: next_s.rdat = {16'h0000, s.period};
        ADR_END[7:2]: next_s.rdat = {16'h0000, s.endc};
        ADR_WAIT[7:2]: next_s.rdat = {16'h0000, s.waitc};
        ADR_BUF[7:2]: next_s.rdat = {16'h0000, s.bufd};
        ADR_STAT[7:2]: next_s.rdat = {27'h000_0000, s.fsm == ST_COUNT, s.stat};
        default: next_s.rdat = 32'h0000_0000;
      endcase
      if (WB_WE) begin
        unique case (WB_ADR[7:2])
          ADR_MODE[7:2]: next_s.mode = 6'(lanes({26'h0, s.mode}, WB_DAT_I, WB_SEL));
          ADR_CTRL1[7:2]: next_s.ctrl1 = 8'(lanes({24'h0, s.ctrl1}, WB_DAT_I, WB_SEL));
          ADR_CTRL2[7:2]: next_s.ctrl2 = 8'(lanes({24'h0, s.ctrl2}, WB_DAT_I, WB_SEL))
                                         & ~CTRL2_ONES;
          ADR_COUNT[7:2]: next_s.cnt = 16'(lanes({16'h0, s.cnt}, WB_DAT_I, WB_SEL));
          ADR_PERIOD[7:2]: next_s.period = 16'(lanes({16'h0, s.period}, WB_DAT_I, WB_SEL));
          ADR_END[7:2]: next_s.endc = 16'(lanes({16'h0, s.endc}, WB_DAT_I, WB_SEL));
          ADR_WAIT[7:2]: next_s.waitc = 16'(lanes({16'h0, s.waitc}, WB_DAT_I, WB_SEL));
          ADR_BUF[7:2]: next_s.bufd = 16'(lanes({16'h0, s.bufd}, WB_DAT_I, WB_SEL));
          ADR_STAT[7:2]: next_s.stat = (s.stat & ~(WB_SEL[0] ? WB_DAT_I[3:0] : 4'h0)) | ev;
          default: next_s.stat = next_s.stat;
        endcase
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      s.fsm <= ST_IDLE;
      s.mode <= MODE_RST;
      s.ctrl1 <= CTRL1_RST;
      s.ctrl2 <= CTRL2_RST;
      s.cnt <= COUNT_RST;
      s.period <= CMP_RST;
      s.endc <= CMP_RST;
      s.waitc <= CMP_RST;
      s.bufd <= CMP_RST;
      s.div <= 5'h00;
      s.stat <= 4'h0;
      s.active <= 1'b0;
      s.oe_n <= 1'b1;
      s.irq <= 1'b0;
      s.adc <= 1'b0;
      s.ack <= 1'b0;
      s.rdat <= 32'h0000_0000;
    end else begin
      s <= next_s;
    end
  end

  assign WB_DAT_O = s.rdat;
  assign WB_ACK = s.ack;
  assign PULSE_OUT_O = s.active ^ s.ctrl1[CTRL1_POL];
  assign PULSE_OUT_OE_N = s.oe_n;
  assign IRQ_REQ = s.irq;
  assign ADC_TRIG = s.adc;

  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);

  property p_stop_level;
    s.fsm == ST_COUNT && !run |=> !s.active && s.fsm == ST_IDLE && s.cnt == $past(s.cnt);
  endproperty
  a_stop_level: assert property (p_stop_level) else $error("run clear left pulse active");

  property p_polarity;
    $rose(s.active) && !s.ctrl1[CTRL1_POL] |-> PULSE_OUT_O;
  endproperty
  a_polarity: assert property (p_polarity) else $error("active level wrong");

  property p_wait_match;
    s.fsm == ST_COUNT && run && en && tick && s.cnt == s.waitc && s.cnt != s.endc
      && !(stop && s.cnt == s.period) |=> s.active;
  endproperty
  a_wait_match: assert property (p_wait_match) else $error("wait match missed");

  property p_end_match;
    s.fsm == ST_COUNT && run && en && tick && s.cnt == s.endc |=> !s.active;
  endproperty
  a_end_match: assert property (p_end_match) else $error("end match missed");

  property p_period_clear;
    s.fsm == ST_COUNT && run && en && tick && stop && clr && s.cnt == s.period && !cnt_wr
      |=> s.cnt == COUNT_RST && s.fsm != ST_COUNT;
  endproperty
  a_period_clear: assert property (p_period_clear) else $error("period stop no clear");

  property p_period_stop;
    s.fsm == ST_COUNT && run && en && tick && stop && s.cnt == s.period
      |=> !s.active && s.fsm != ST_COUNT;
  endproperty
  a_period_stop: assert property (p_period_stop) else $error("counter not halted");

  property p_increment;
    s.fsm == ST_COUNT && run && en && tick && s.cnt != s.period && !cnt_wr
      |=> s.cnt == $past(s.cnt) + 16'h0001;
  endproperty
  a_increment: assert property (p_increment) else $error("counter did not step");

  property p_armed_hold;
    s.fsm == ST_ARMED && !trig_hit |=> s.fsm != ST_COUNT;
  endproperty
  a_armed_hold: assert property (p_armed_hold) else $error("started without edge");

  property p_free_start;
    s.fsm == ST_IDLE && run && en && !trig_mode |=> s.fsm == ST_COUNT;
  endproperty
  a_free_start: assert property (p_free_start) else $error("run did not start");

  property p_irq;
    s.fsm == ST_COUNT && run && en && tick && s.cnt == s.period |=> IRQ_REQ && s.stat[EV_A];
  endproperty
  a_irq: assert property (p_irq) else $error("no request on match");

  property p_ack_pulse;
    WB_ACK |=> !WB_ACK;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held two cycles");

  // Outside a count the pin must sit at its initial level
  property p_idle_level;
    s.fsm != ST_COUNT |-> PULSE_OUT_O == s.ctrl1[CTRL1_POL];
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("initial level wrong");

  property p_cutoff;
    en && s.mode[MODE_CUT] && !pins[PIN_CUT].level |=> PULSE_OUT_OE_N;
  endproperty
  a_cutoff: assert property (p_cutoff) else $error("cutoff ignored");

  property p_drive;
    en && !s.mode[MODE_CUT] |=> !PULSE_OUT_OE_N;
  endproperty
  a_drive: assert property (p_drive) else $error("pulse pin not driven");

  property p_trig_start;
    s.fsm == ST_ARMED && run && en && trig_hit |=> s.fsm == ST_COUNT;
  endproperty
  a_trig_start: assert property (p_trig_start) else $error("edge did not start");

  property p_adc;
    s.fsm == ST_COUNT && run && en && tick && s.cnt == s.waitc && s.mode[MODE_ADC]
      |=> ADC_TRIG;
  endproperty
  a_adc: assert property (p_adc) else $error("converter trigger missed");

  c_pulse: cover property ($rose(s.active) ##[1:1000] $fell(s.active));
  c_trigger: cover property (s.fsm == ST_ARMED ##1 s.fsm == ST_COUNT);
  c_stop: cover property (s.fsm == ST_COUNT ##1 s.fsm == ST_ARMED);
  c_cutoff: cover property (en && $rose(PULSE_OUT_OE_N));
  c_free: cover property (s.fsm == ST_IDLE ##1 s.fsm == ST_COUNT);
endmodule // osp_one_shot_pwm

// ===== src/osp_pkg.sv
// Package: register map, field positions, reset values and carrier types
package osp_pkg;
  localparam logic [7:0] ADR_MODE = 8'h00;
  localparam logic [7:0] ADR_CTRL1 = 8'h04;
  localparam logic [7:0] ADR_CTRL2 = 8'h08;
  localparam logic [7:0] ADR_COUNT = 8'h0C;
  localparam logic [7:0] ADR_PERIOD = 8'h10;
  localparam logic [7:0] ADR_END = 8'h14;
  localparam logic [7:0] ADR_WAIT = 8'h18;
  localparam logic [7:0] ADR_BUF = 8'h1C;
  localparam logic [7:0] ADR_STAT = 8'h20;

  localparam int MODE_RUN = 0;
  localparam int MODE_EN = 1;
  localparam int MODE_BUF = 2;
  localparam int MODE_CUT = 3;
  localparam int MODE_ADC = 4;
  localparam int MODE_FILT = 5;
  localparam int CTRL1_POL = 1;
  localparam int CTRL1_SRC = 4;
  localparam int CTRL1_CLR = 7;
  localparam int CTRL2_STOP = 5;
  localparam int CTRL2_EDGE = 6;
  localparam int EV_A = 0;
  localparam int EV_B = 1;
  localparam int EV_C = 2;
  localparam int EV_OVF = 3;
  localparam int PIN_TRIG = 0;
  localparam int PIN_ECLK = 1;
  localparam int PIN_CUT = 2;
  localparam int NPINS = 3;

  localparam logic [5:0] MODE_RST = 6'h00;
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] CTRL2_RST = 8'h00;
  localparam logic [7:0] CTRL2_ONES = 8'h18;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] CMP_RST = 16'hFFFF;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;

  typedef enum logic [2:0] {
    SRC_F1 = 3'h0, SRC_F2 = 3'h1, SRC_F4 = 3'h2, SRC_F8 = 3'h3,
    SRC_F32 = 3'h4, SRC_EXT = 3'h5, SRC_OSC40 = 3'h6, SRC_OSCDIV = 3'h7
  } osp_src_t;

  typedef enum logic [1:0] {
    EDGE_OFF = 2'h0, EDGE_RISE = 2'h1, EDGE_FALL = 2'h2, EDGE_BOTH = 2'h3
  } osp_edge_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001, ST_ARMED = 3'b010, ST_COUNT = 3'b100
  } osp_fsm_t;

  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } osp_pin_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic h1;
    logic h2;
    osp_pin_t q;
  } osp_sync_t;

  typedef struct packed {
    osp_fsm_t fsm;
    logic [5:0] mode;
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [15:0] cnt;
    logic [15:0] period;
    logic [15:0] endc;
    logic [15:0] waitc;
    logic [15:0] bufd;
    logic [4:0] div;
    logic [3:0] stat;
    logic active;
    logic oe_n;
    logic irq;
    logic adc;
    logic ack;
    logic [31:0] rdat;
  } osp_state_t;
endpackage

// ===== src/osp_pin_sync.sv
// Pin synchroniser with optional three-sample filter and edge pulses
`timescale 1ns/1ns
module osp_pin_sync import osp_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin,
  input wire logic filt_en,
  output osp_pin_t q
);
  osp_sync_t s;
  osp_sync_t next_s;
  logic lvl;

  always_comb begin
    next_s = s;
    next_s.s1 = pin;
    next_s.s2 = s.s1;
    next_s.h1 = s.s2;
    next_s.h2 = s.h1;
    lvl = s.q.level;
    // Filter holds the old level until three samples agree
    if (!filt_en) begin
      lvl = s.s2;
    end else if (s.s2 == s.h1 && s.h1 == s.h2) begin
      lvl = s.s2;
    end
    next_s.q.level = lvl;
    next_s.q.rise = lvl & ~s.q.level;
    next_s.q.fall = ~lvl & s.q.level;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q = s.q;
endmodule // osp_pin_sync

// ===== dv/osp_far_side.sv
// Far-side model: trigger source, external count clock, cutoff line and pulse load
`timescale 1ns/1ns
module osp_far_side (
  input wire logic clk,
  input wire logic pulse,
  input wire logic oe_n,
  output logic trig,
  output logic eclk,
  output logic cut_n
);
  int run = 0;
  int hi_len = 0;
  int lo_len = 0;
  int n_rise = 0;
  logic last = 1'b0;
  initial begin
    trig = 1'b0;
    eclk = 1'b0;
    cut_n = 1'b1;
  end
  // Load samples mid-cycle, so run lengths come out in whole clock cycles
  always @(negedge clk) begin
    if (oe_n === 1'b0 && pulse !== last) begin
      if (last) begin
        hi_len <= run;
      end else begin
        lo_len <= run;
      end
      n_rise <= n_rise + int'(pulse === 1'b1);
      run <= 1;
    end else begin
      run <= run + 1;
    end
    last <= pulse;
  end
  task automatic set_trig(input logic v);
    @(posedge clk);
    trig <= v;
  endtask
  // Each level is held several cycles so the synchroniser cannot miss it
  task automatic eclk_rises(input int n);
    repeat (n) begin
      @(posedge clk);
      eclk <= 1'b1;
      repeat (3) @(posedge clk);
      eclk <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
  task automatic set_cut(input logic v);
    @(posedge clk);
    cut_n <= v;
  endtask
endmodule // osp_far_side

// ===== dv/osp_one_shot_pwm_tb.sv
// Self-checking testbench for the triggered one-shot PWM timer
`timescale 1ns/1ns
module osp_one_shot_pwm_tb import osp_pkg::*;;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dati = 32'h0000_0000;
  logic tick = 1'b0;
  logic dtick = 1'b0;
  logic [31:0] dato;
  logic [31:0] q;
  logic ack, trig, eclk, cut_n, pulse, oe_n, irq, adc;
  int error_cnt = 0;
  int n_tests = 0;
  int n_irq = 0;
  int n_adc = 0;
  int n0;
  int a0;
  osp_one_shot_pwm i_osp_one_shot_pwm (.REF_CLK(ref_clk), .RST(rst), .WB_CYC(cyc),
    .WB_STB(stb), .WB_WE(we), .WB_ADR(adr), .WB_SEL(sel), .WB_DAT_I(dati), .WB_DAT_O(dato),
    .WB_ACK(ack), .CHAN_A_I(trig), .EXT_CLK_I(eclk), .CUTOFF_N_I(cut_n),
    .FAST_OSC_TICK(tick), .FAST_OSC_DIV_TICK(dtick), .PULSE_OUT_O(pulse),
    .PULSE_OUT_OE_N(oe_n), .IRQ_REQ(irq), .ADC_TRIG(adc));
  osp_far_side i_osp_far_side (.clk(ref_clk), .pulse(pulse), .oe_n(oe_n), .trig(trig),
    .eclk(eclk), .cut_n(cut_n));
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  always @(negedge ref_clk) begin
    n_irq <= n_irq + int'(irq === 1'b1);
    n_adc <= n_adc + int'(adc === 1'b1);
  end
  task automatic summarize();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string s, input int e, input logic [31:0] g);
    n_tests++;
    if (g !== 32'(e)) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", s, 32'(e), g);
    end
  endtask
  // Ack and read data are taken at the rising edge, before that edge's update lands
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dati <= d;
    sel <= 4'hF;
    do begin
      @(posedge ref_clk);
      i++;
    end while (ack !== 1'b1 && i < 50);
    q = dato;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (ack !== 1'b1) begin
      error_cnt++;
      summarize();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rdchk(input string s, input logic [7:0] a, input int e);
    bus(a, 1'b0, 32'h0000_0000);
    chk(s, e, q);
  endtask
  task automatic run(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic t_reset();
    logic [7:0] a[7] = '{ADR_MODE, ADR_CTRL1, ADR_CTRL2, ADR_COUNT, ADR_PERIOD, ADR_STAT, 8'h3C};
    int e[7] = '{0, 0, 'h18, 0, 'hFFFF, 0, 0};
    chk("oe_n", 1, 32'(oe_n));
    for (int i = 0; i < 7; i++) begin
      rdchk("reset", a[i], e[i]);
    end
  endtask
  task automatic t_free(input logic pol);
    logic [31:0] c;
    wr(ADR_MODE, 32'h0000_0000);
    wr(ADR_CTRL1, 32'h0000_0080 | (32'(pol) << 1));
    wr(ADR_CTRL2, 32'h0000_0000);
    wr(ADR_PERIOD, 32'h0000_0009);
    wr(ADR_END, 32'h0000_0006);
    wr(ADR_WAIT, 32'h0000_0002);
    wr(ADR_COUNT, 32'h0000_0000);
    n0 = n_irq;
    a0 = n_adc;
    wr(ADR_MODE, 32'h0000_0013);
    run(45);
    chk("width", 4, pol ? i_osp_far_side.lo_len : i_osp_far_side.hi_len);
    chk("period", 10, i_osp_far_side.hi_len + i_osp_far_side.lo_len);
    chk("wait", 6, pol ? i_osp_far_side.hi_len : i_osp_far_side.lo_len);
    chk("irq", 1, 32'(n_irq > n0));
    chk("adc", 1, 32'(n_adc > a0));
    chk("oe_n", 0, 32'(oe_n));
    wr(ADR_MODE, 32'h0000_0002);
    run(3);
    chk("idle", pol, 32'(pulse));
    bus(ADR_COUNT, 1'b0, 32'h0000_0000);
    c = q;
    run(5);
    rdchk("kept", ADR_COUNT, c);
    bus(ADR_STAT, 1'b0, 32'h0000_0000);
    chk("match", 1, 32'(q[0]));
    wr(ADR_STAT, 32'h0000_000F);
    bus(ADR_STAT, 1'b0, 32'h0000_0000);
    chk("stat", 0, 32'(q[3:0]));
  endtask
  task automatic t_sw();
    wr(ADR_MODE, 32'h0000_0000);
    wr(ADR_CTRL1, 32'h0000_0080);
    wr(ADR_CTRL2, 32'h0000_0020);
    wr(ADR_COUNT, 32'h0000_0000);
    wr(ADR_BUF, 32'h0000_0005);
    n0 = i_osp_far_side.n_rise;
    wr(ADR_MODE, 32'h0000_0007);
    run(40);
    chk("pulses", 1, i_osp_far_side.n_rise - n0);
    bus(ADR_MODE, 1'b0, 32'h0000_0000);
    chk("run", 0, 32'(q[0]));
    rdchk("buffer", ADR_END, 5);
  endtask
  task automatic t_trig(input int code, input logic clr);
    wr(ADR_MODE, 32'h0000_0000);
    i_osp_far_side.set_trig(code == 1);
    run(6);
    wr(ADR_CTRL1, 32'(clr) << 7);
    wr(ADR_CTRL2, 32'h0000_0020 | (32'(code) << 6));
    wr(ADR_COUNT, 32'h0000_0000);
    n0 = i_osp_far_side.n_rise;
    wr(ADR_MODE, 32'h0000_0003);
    i_osp_far_side.set_trig(code != 1);
    run(30);
    chk("first", 32'(code == 3), i_osp_far_side.n_rise - n0);
    i_osp_far_side.set_trig(code == 1);
    run(30);
    chk("second", code == 3 ? 2 : 1, i_osp_far_side.n_rise - n0);
    rdchk("stopped", ADR_COUNT, clr ? 0 : 9);
    chk("idle", 0, 32'(pulse));
    bus(ADR_STAT, 1'b0, 32'h0000_0000);
    chk("held", 0, 32'(q[4]));
  endtask
  task automatic t_src();
    for (int s = 5; s < 8; s++) begin
      wr(ADR_MODE, 32'h0000_0000);
      wr(ADR_CTRL1, 32'(s) << 4);
      wr(ADR_CTRL2, 32'h0000_0000);
      wr(ADR_COUNT, 32'h0000_0003);
      wr(ADR_MODE, 32'h0000_0003);
      if (s == 5) begin
        i_osp_far_side.eclk_rises(5);
      end else begin
        repeat (5) begin
          @(posedge ref_clk);
          tick <= (s == 6);
          dtick <= (s == 7);
          @(posedge ref_clk);
          tick <= 1'b0;
          dtick <= 1'b0;
        end
      end
      run(6);
      wr(ADR_MODE, 32'h0000_0000);
      rdchk("ticks", ADR_COUNT, 8);
    end
  endtask
  // Divided sources: a 64-cycle count window holds a whole number of ticks for each
  task automatic t_div();
    int e[5] = '{64, 32, 16, 8, 2};
    for (int k = 0; k < 5; k++) begin
      wr(ADR_MODE, 32'h0000_0000);
      wr(ADR_CTRL1, 32'(k) << 4);
      wr(ADR_CTRL2, 32'h0000_0000);
      wr(ADR_COUNT, 32'h0000_0000);
      wr(ADR_MODE, 32'h0000_0003);
      run(62);
      wr(ADR_MODE, 32'h0000_0000);
      rdchk("divided", ADR_COUNT, e[k]);
    end
  endtask
  task automatic t_cut();
    wr(ADR_MODE, 32'h0000_002B);
    run(4);
    chk("drive", 0, 32'(oe_n));
    i_osp_far_side.set_cut(1'b0);
    run(8);
    chk("cut", 1, 32'(oe_n));
    i_osp_far_side.set_cut(1'b1);
    run(8);
    chk("resume", 0, 32'(oe_n));
  endtask
  initial begin
    run(8);
    rst <= 1'b0;
    t_reset();
    t_free(1'b0);
    t_free(1'b1);
    t_sw();
    for (int k = 1; k < 4; k++) begin
      t_trig(k, 1'b1);
    end
    t_trig(1, 1'b0);
    t_src();
    t_div();
    t_cut();
    summarize();
  end
endmodule // osp_one_shot_pwm_tb
